// [verilog/hrxcfg_top.sv]
/*
 * receive data fifo readout configuration: end padding, leading offset,
 * dword transfer countdown with completion interrupt and a discard command.
 * assumes the fifo sits outside; this block shapes each host read and reports pops.
 */
// Operation
// [RULE_01] pad the last buffer transfer with dwords to 4, 16 or 32 byte boundary
// [RULE_02] host throws away the padding dwords, device never removes them
// [RULE_03] host sets end alignment before a packet, never mid packet
// [RULE_04] hold 12-bit dword count, raise transfer complete when that many read
// [RULE_05] each dword read from the data fifo decrements the loaded count
// [RULE_06] a new count written before zero replaces the running count
// [RULE_07] writing one to discard flushes data and status fifos, pointers to zero
// [RULE_08] insert leading offset bytes ahead of each packet's data; the code inserts off_q[4:2] zero dwords and ignores the low two offset bits
// [RULE_09] every leading offset from zero to thirty-one bytes is valid
// [RULE_10] host changes low offset bits only with receiver halted and purged
// [RULE_11] upper offset bits may change live, taking effect on next dword read
// [RULE_12] transfer complete reaches the interrupt output only when enable bit set
// [RULE_13] count stays at zero, no second interrupt until a new count is written
module hrxcfg_top (
	input  wire logic                   clk_i,
	input  wire logic                   rst_b_i,
	input  wire hrxcfg_pkg::hrx_reg_wr_s reg_wr_i,
	input  wire logic [7:0]             reg_rd_addr_i,
	output logic      [31:0]            reg_rd_data_o,
	input  wire logic [31:0]            int_en_i,
	input  wire logic                   fifo_valid_i,
	input  wire logic [31:0]            fifo_data_i,
	input  wire logic                   fifo_last_i,
	output logic                        fifo_pop_o,
	output logic                        fifo_flush_o,
	input  wire logic                   host_rd_i,
	output hrxcfg_pkg::hrx_dword_s      host_dword_o,
	output logic                        host_ready_o,
	output logic                        xfer_done_o,
	output logic                        irq_o
);
	// -------------------------------------------------------------------------
	// configuration register
	// -------------------------------------------------------------------------
	logic [1:0]  ea_q;
	logic [11:0] cnt_q;
	logic [4:0]  off_q;
	logic        flush_q;
	logic        done_q;
	logic        cfg_wr;
	logic        rd_take;
	logic        pop;

	assign cfg_wr  = reg_wr_i.wr && (reg_wr_i.addr == hrxcfg_pkg::RXCFG_OFFSET);

	// alignment and offset fields
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ea_q  <= hrxcfg_pkg::EA_RESET;
			off_q <= hrxcfg_pkg::OFFSET_RESET;
		end else if (cfg_wr) begin
			ea_q  <= reg_wr_i.data[hrxcfg_pkg::EA_LSB +: 2];
			off_q <= reg_wr_i.data[hrxcfg_pkg::OFFSET_LSB +: 5]; // RULE_09
		end
	end

	// -------------------------------------------------------------------------
	// transfer count and completion
	// -------------------------------------------------------------------------
	// dword countdown; a write wins over a same-cycle decrement
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= hrxcfg_pkg::CNT_RESET;
		end else if (cfg_wr) begin
			cnt_q <= reg_wr_i.data[hrxcfg_pkg::CNT_LSB +: 12]; // RULE_06
		end else if (pop && cnt_q != 12'h000) begin
			cnt_q <= cnt_q - 12'h001; // RULE_05
		end
	end

	// completion level: set by the pop at count one, cleared by a new count write; that pop wins over a same-cycle write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			done_q <= 1'b0;
		end else if (pop && cnt_q == 12'h001) begin
			done_q <= 1'b1; // RULE_04
		end else if (cfg_wr) begin
			done_q <= 1'b0; // RULE_13
		end
	end

	// -------------------------------------------------------------------------
	// discard command and interrupt
	// -------------------------------------------------------------------------
	// self clearing discard pulse
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flush_q <= 1'b0;
		end else begin
			flush_q <= cfg_wr && reg_wr_i.data[hrxcfg_pkg::DISCARD_BIT]; // RULE_07
		end
	end

	assign fifo_flush_o = flush_q; // RULE_07
	assign xfer_done_o  = done_q;
	assign irq_o        = done_q && int_en_i[hrxcfg_pkg::INT_EN_RXD_BIT]; // RULE_12

	// -------------------------------------------------------------------------
	// register read back
	// -------------------------------------------------------------------------
	// read back; discard bit reads zero, reserved bits zero
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rd_data_o <= 32'h00000000;
		end else if (reg_rd_addr_i == hrxcfg_pkg::RXCFG_OFFSET) begin
			reg_rd_data_o <= {ea_q, 2'h0, cnt_q, 3'h0, off_q, 8'h00};
		end else begin
			reg_rd_data_o <= 32'h00000000;
		end
	end

	// -------------------------------------------------------------------------
	// readout shaper
	// -------------------------------------------------------------------------
	hrxcfg_pkg::hrx_state_e state_q;
	logic [2:0]  lead_q;     // leading dwords left
	logic [3:0]  pad_q;      // dwords read in current boundary
	logic [3:0]  ea_dw;
	logic [3:0]  pad_next;
	logic        last_data;
	logic        lead_any;   // upper offset bits ask for leading dwords

	// boundary size in dwords
	always_comb begin
		case (ea_q)
			hrxcfg_pkg::EA_16B: ea_dw = hrxcfg_pkg::EA_DW_16B;
			hrxcfg_pkg::EA_32B: ea_dw = hrxcfg_pkg::EA_DW_32B;
			default:            ea_dw = hrxcfg_pkg::EA_DW_4B; // reserved treated as 4 byte
		endcase
	end

	assign lead_any     = (off_q[4:2] != 3'h0);
	assign rd_take      = host_rd_i && host_ready_o;
	// idle waits for a stored packet before the first read; lead and pad dwords need no fifo word
	assign host_ready_o = !flush_q && (state_q == hrxcfg_pkg::HRX_LEAD || state_q == hrxcfg_pkg::HRX_PAD
		|| ((state_q == hrxcfg_pkg::HRX_DATA || state_q == hrxcfg_pkg::HRX_IDLE) && fifo_valid_i));
	assign pop          = rd_take && (state_q == hrxcfg_pkg::HRX_DATA
		|| (state_q == hrxcfg_pkg::HRX_IDLE && !lead_any));
	assign fifo_pop_o   = pop;
	assign last_data    = pop && fifo_last_i;
	assign pad_next     = (pad_q + 4'h1 == ea_dw) ? 4'h0 : pad_q + 4'h1;

	// -------------------------------------------------------------------------
	// packet sequencer
	// -------------------------------------------------------------------------
	// packet sequence: leading dwords, data, end padding
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= hrxcfg_pkg::HRX_IDLE;
			lead_q  <= 3'h0;
			pad_q   <= 4'h0;
		end else if (flush_q) begin
			state_q <= hrxcfg_pkg::HRX_IDLE; // RULE_07
			lead_q  <= 3'h0;
			pad_q   <= 4'h0;
		end else begin
			case (state_q)
				hrxcfg_pkg::HRX_IDLE: begin
					pad_q <= 4'h0;
					if (rd_take && lead_any) begin
						// offset taken at the first read, so a live change of the upper bits lands there
						pad_q   <= pad_next;
						lead_q  <= off_q[4:2] - 3'h1; // RULE_11
						state_q <= (off_q[4:2] == 3'h1) ? hrxcfg_pkg::HRX_DATA : hrxcfg_pkg::HRX_LEAD; // RULE_08
					end else if (pop) begin
						pad_q   <= pad_next;
						state_q <= (fifo_last_i && pad_next != 4'h0) ? hrxcfg_pkg::HRX_PAD
							: (fifo_last_i ? hrxcfg_pkg::HRX_IDLE : hrxcfg_pkg::HRX_DATA);
					end
				end
				hrxcfg_pkg::HRX_LEAD: begin
					if (rd_take) begin
						pad_q  <= pad_next;
						lead_q <= lead_q - 3'h1;
						if (lead_q == 3'h1) begin
							state_q <= hrxcfg_pkg::HRX_DATA;
						end
					end
				end
				hrxcfg_pkg::HRX_DATA: begin
					if (pop) begin
						pad_q <= pad_next;
						if (last_data) begin
							state_q <= (pad_next != 4'h0) ? hrxcfg_pkg::HRX_PAD : hrxcfg_pkg::HRX_IDLE; // RULE_01
						end
					end
				end
				hrxcfg_pkg::HRX_PAD: begin
					if (rd_take) begin
						pad_q <= pad_next; // RULE_01
						if (pad_next == 4'h0) begin
							state_q <= hrxcfg_pkg::HRX_IDLE;
						end
					end
				end
				default: begin
					state_q <= hrxcfg_pkg::HRX_IDLE;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// output dword
	// -------------------------------------------------------------------------
	// registered output dword; leading and pad dwords carry zero data
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			host_dword_o <= '0;
		end else if (rd_take) begin
			host_dword_o.pad  <= (state_q == hrxcfg_pkg::HRX_PAD);
			host_dword_o.lead <= (state_q == hrxcfg_pkg::HRX_LEAD)
				|| (state_q == hrxcfg_pkg::HRX_IDLE && lead_any); // RULE_08
			host_dword_o.data <= pop ? fifo_data_i : 32'h00000000; // RULE_08
		end
	end
endmodule : hrxcfg_top

// [verilog/hrxcfg_pkg.sv]
/*
 * package for the receive engine configuration block: register offset, field positions,
 * reset values and carrier structs.
 * assumes a synchronous register port and a single system clock.
 */
package hrxcfg_pkg;
	// -------------------------------------------------------------------------
	// register map
	// -------------------------------------------------------------------------
	localparam logic [7:0]  RXCFG_OFFSET       = 8'h6C;
	localparam int          EA_LSB             = 30;
	localparam int          CNT_LSB            = 16;
	localparam int          DISCARD_BIT        = 15;
	localparam int          OFFSET_LSB         = 8;
	localparam int          INT_EN_RXD_BIT     = 20;
	localparam logic [1:0]  EA_RESET           = 2'h0;
	localparam logic [11:0] CNT_RESET          = 12'h000;
	localparam logic [4:0]  OFFSET_RESET       = 5'h00;
	// end alignment encodings, then boundary sizes in dwords per boundary
	localparam logic [1:0]  EA_4B              = 2'h0;
	localparam logic [1:0]  EA_16B             = 2'h1;
	localparam logic [1:0]  EA_32B             = 2'h2;
	localparam logic [3:0]  EA_DW_4B           = 4'h1;
	localparam logic [3:0]  EA_DW_16B          = 4'h4;
	localparam logic [3:0]  EA_DW_32B          = 4'h8;

	typedef enum logic [1:0] {
		HRX_IDLE = 2'b00,
		HRX_LEAD = 2'b01,
		HRX_DATA = 2'b10,
		HRX_PAD  = 2'b11
	} hrx_state_e;

	// register write strobe with data
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] data;
	} hrx_reg_wr_s;

	// one dword leaving the receive data fifo towards the host
	typedef struct packed {
		logic        pad;
		logic        lead;
		logic [31:0] data;
	} hrx_dword_s;
endpackage : hrxcfg_pkg

// [sim/hrxcfg_properties.sv]
/* port checker for hrxcfg_top, bound to it below
   assumes one clock and an active low async reset */
module hrxcfg_properties (
	input wire logic                   clk_i,
	input wire logic                   rst_b_i,
	input wire hrxcfg_pkg::hrx_reg_wr_s reg_wr_i,
	input wire logic [31:0]            int_en_i,
	input wire logic                   fifo_valid_i,
	input wire logic [31:0]            fifo_data_i,
	input wire logic                   fifo_pop_o,
	input wire logic                   fifo_flush_o,
	input wire logic                   host_rd_i,
	input wire hrxcfg_pkg::hrx_dword_s host_dword_o,
	input wire logic                   host_ready_o,
	input wire logic                   xfer_done_o,
	input wire logic                   irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic wr_cfg;
	logic wr_disc;
	// config writes and discard commands
	assign wr_cfg  = reg_wr_i.wr && reg_wr_i.addr == 8'h6C;
	assign wr_disc = wr_cfg && reg_wr_i.data[15];
	a_irq_gate: assert property (irq_o == (xfer_done_o && int_en_i[20])) else $error("irq gate");
	a_flush_pulse: assert property (wr_disc ##1 !wr_disc |-> fifo_flush_o ##1 !fifo_flush_o) else $error("flush");
	a_flush_cause: assert property (fifo_flush_o |-> $past(wr_disc)) else $error("stray flush");
	a_done_rise: assert property ($rose(xfer_done_o) |-> $past(fifo_pop_o)) else $error("done");
	a_done_clear: assert property (wr_cfg && !fifo_pop_o |=> !xfer_done_o) else $error("clear");
	a_done_hold: assert property (xfer_done_o && !wr_cfg |=> xfer_done_o) else $error("hold");
	a_pop_accept: assert property (fifo_pop_o |-> fifo_valid_i && host_rd_i && host_ready_o) else $error("pop");
	a_pop_data: assert property (fifo_pop_o |=> host_dword_o.data == $past(fifo_data_i)) else $error("data");
	a_fill_read: assert property (host_rd_i && host_ready_o && !fifo_pop_o |=>
		host_dword_o.pad || host_dword_o.lead) else $error("filler");
	a_lead_zero: assert property (host_dword_o.lead |-> host_dword_o.data == 32'h0) else $error("lead");
	c_flush: cover property (fifo_flush_o);
	c_irq: cover property (irq_o);
	c_pad: cover property (host_dword_o.pad);
	c_lead: cover property (host_dword_o.lead);
endmodule : hrxcfg_properties
bind hrxcfg_top hrxcfg_properties i_hrxcfg_properties (.clk_i, .rst_b_i, .reg_wr_i, .int_en_i, .fifo_valid_i,
	.fifo_data_i, .fifo_pop_o, .fifo_flush_o, .host_rd_i, .host_dword_o, .host_ready_o, .xfer_done_o, .irq_o);

// [sim/hrxcfg_fifo_model.sv]
/* receive data fifo model feeding the readout block
   assumes pop and flush are sampled at the rising edge */
module hrxcfg_fifo_model (
	input  wire logic        clk_i,
	input  wire logic        fifo_pop_i,
	input  wire logic        fifo_flush_i,
	output logic             fifo_valid_o,
	output logic      [31:0] fifo_data_o,
	output logic             fifo_last_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [32:0] q[$];
	task automatic push(input logic [32:0] w);
		q.push_back(w);
	endtask : push
	// flush empties everything, a pop drops the head
	always @(posedge clk_i) begin
		if (fifo_flush_i) q.delete();
		else if (fifo_pop_i && q.size() > 0) void'(q.pop_front());
	end
	// head shown at the falling edge; empty shows a toggling pattern
	initial {fifo_valid_o, fifo_last_o, fifo_data_o} = '0;
	always @(negedge clk_i) begin
		fifo_valid_o = q.size() > 0;
		fifo_last_o  = fifo_valid_o ? q[0][32] : ~fifo_last_o;
		fifo_data_o  = fifo_valid_o ? q[0][31:0] : ~fifo_data_o;
	end
endmodule : hrxcfg_fifo_model

// [sim/hrxcfg_tb_top.sv]
/* self-checking bench for hrxcfg_top with a fifo model on the far side
   assumes register reads answer one cycle after the address */
module hrxcfg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	hrxcfg_pkg::hrx_reg_wr_s reg_wr = '0;
	hrxcfg_pkg::hrx_dword_s  dw;
	logic [7:0]  rd_addr = 8'h00;
	logic [31:0] rd_data, fd, r, int_en = 32'h0, seed = 32'hE9DCC4B7;
	logic        clk = 1'b0, rst_b = 1'b0, hrd = 1'b0, fv, fl, pop, flush, ready, done, irq;
	int          failures = 0, checked = 0;
	always #2 clk = ~clk;
	hrxcfg_top i_hrxcfg_top (.clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(reg_wr), .reg_rd_addr_i(rd_addr),
		.reg_rd_data_o(rd_data), .int_en_i(int_en), .fifo_valid_i(fv), .fifo_data_i(fd), .fifo_last_i(fl),
		.fifo_pop_o(pop), .fifo_flush_o(flush), .host_rd_i(hrd), .host_dword_o(dw), .host_ready_o(ready),
		.xfer_done_o(done), .irq_o(irq));
	hrxcfg_fifo_model i_hrxcfg_fifo_model (.clk_i(clk), .fifo_pop_i(pop), .fifo_flush_i(flush),
		.fifo_valid_o(fv), .fifo_data_o(fd), .fifo_last_o(fl));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// padded dword total of one packet
	function automatic int total(input logic [1:0] ea, input int n);
		int b;
		b = ea == 2'h2 ? 8 : ea == 2'h1 ? 4 : 1;
		return (n + b - 1) / b * b;
	endfunction : total
	task automatic wrap_up();
		if (failures == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk) reg_wr = '{1'b1, a, d};
		@(negedge clk) reg_wr.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk) rd_addr = a;
		@(negedge clk) chk(rd_data, e);
	endtask : rd
	// one packet: load config, read lead, data and pad dwords, check the count
	task automatic packet(input logic [1:0] ea, input logic [4:0] off, input int len, input int cnt);
		int n;
		int lead;
		lead = off[4:2];
		for (int i = 0; i < len; i++) i_hrxcfg_fifo_model.push({i == len - 1, 32'hA5000000 + i});
		wr(8'h6C, {ea, 2'h0, cnt[11:0], 3'h0, off, 8'h00});
		hrd = 1'b1;
		for (int i = 0; i < total(ea, lead + len); i++) begin
			#1;
			for (n = 0; n < 20 && ready !== 1'b1; n++) @(negedge clk) #1;
			if (n == 20) begin
				failures++;
				wrap_up();
			end
			@(negedge clk) chk({dw.lead, dw.pad}, {i < lead, i >= lead + len});
			if (!dw.pad) chk(dw.data, i < lead ? 32'h0 : 32'hA5000000 + i - lead);
		end
		hrd = 1'b0;
		n = cnt > len ? cnt - len : 0;
		chk(done, cnt != 0 && cnt <= len);
		chk(irq, cnt != 0 && cnt <= len && int_en[20]);
		rd(8'h6C, {ea, 2'h0, n[11:0], 3'h0, off, 8'h00});
	endtask : packet
	initial begin
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		rd(8'h6C, 32'h0);
		wr(8'h70, 32'hFFFFFFFF);
		rd(8'h70, 32'h0);
		rd(8'h6C, 32'h0);
		for (int k = 0; k < 30; k++) begin
			r = rnd();
			int_en = rnd();
			packet(k < 4 ? k[1:0] : r[31:30], k == 1 ? 5'h1C : {r[7:5], 2'h0}, 1 + r[3:0], r[19:16]);
		end
		for (int i = 0; i < 3; i++) i_hrxcfg_fifo_model.push({1'b0, 32'h1});
		wr(8'h6C, 32'h00008000);
		chk(flush, 1'b1);
		chk(ready, 1'b0);
		@(negedge clk) #1 chk(fv, 1'b0);
		chk(flush, 1'b0);
		packet(2'h1, 5'h1F, 2, 2);
		wrap_up();
	end
endmodule : hrxcfg_tb_top
